// ===== pkg/rtcc_defs.svh
// Register offsets, field positions and reset values of the clock control block
`ifndef RTCC_DEFS_SVH
`define RTCC_DEFS_SVH
`define RTCC_IDX_CTRL      12'hF3F
`define RTCC_ADDR_CTRL     14'h3CFC
`define RTCC_ADDR_STAT     14'h3D00
`define RTCC_ADDR_MASK     14'h3D04
`define RTCC_ADDR_COUNT    14'h3D08
`define RTCC_ADDR_ALMV     14'h3D0C
`define RTCC_BIT_SYNC      7
`define RTCC_BIT_ALARM     6
`define RTCC_BIT_BCD       4
`define RTCC_BIT_MODE      3
`define RTCC_BIT_DST       1
`define RTCC_BIT_LOCK      0
`define RTCC_CTRL_WMASK    8'h1B
`define RTCC_CTRL_RESET    8'h00
`define RTCC_IRQ_ALARM     0
`define RTCC_IRQ_TICK      1
`define RTCC_IRQ_W         2
`define RTCC_RESP_OKAY     2'h0
`define RTCC_RESP_SLVERR   2'h2
`define RTCC_PRESCALE      16'h0019
`endif

// ===== pkg/rtcc_pkg.sv
// Types shared by the clock control block
package rtcc_pkg;
  typedef enum logic [1:0] {RTCC_IDLE, RTCC_RESP} rtcc_bus_state_t;

  typedef struct packed {
    logic [7:0]  b3;
    logic [7:0]  b2;
    logic [7:0]  b1;
    logic [7:0]  b0;
  } rtcc_count_t;
endpackage

// ===== verilog/rtcc_counter.sv
// Four-byte time counter with binary or decimal digit stepping
`timescale 1ns/1ns
`include "rtcc_defs.svh"
module rtcc_counter #(
  parameter logic [15:0] PRESCALE = `RTCC_PRESCALE
) (
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  input  wire logic                 run,
  input  wire logic                 useBcd,
  input  wire logic                 load,
  input  wire rtcc_pkg::rtcc_count_t loadValue,
  output rtcc_pkg::rtcc_count_t     count,
  output logic                      tick,
  output logic                      busy
);
  typedef struct packed {
    logic [15:0]           pre;
    rtcc_pkg::rtcc_count_t cnt;
    logic                  tick;
    logic                  busy;
  } rtcc_cnt_state_t;

  rtcc_cnt_state_t s_q;
  rtcc_cnt_state_t s_d;

  // One byte step; returns carry in bit 8
  function automatic logic [8:0] stepByte(input logic [7:0] v,
                                          input logic bcd);
    logic [8:0] r;
    r = {1'b0, v} + 9'h001;
    if (bcd) begin
      if (v == 8'h99) begin
        r = 9'h100;
      end else if (v[3:0] >= 4'h9) begin
        r = {1'b0, v[7:4] + 4'h1, 4'h0};
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [8:0] c0;
    logic [8:0] c1;
    logic [8:0] c2;
    logic [8:0] c3;
    c0 = stepByte(s_q.cnt.b0, useBcd);
    c1 = stepByte(s_q.cnt.b1, useBcd);
    c2 = stepByte(s_q.cnt.b2, useBcd);
    c3 = stepByte(s_q.cnt.b3, useBcd);
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.busy = 1'b0;
    if (load) begin
      s_d.cnt = loadValue;
    end
    if (!run) begin
      s_d.pre = 16'h0000;
    end else if (s_q.pre == PRESCALE - 16'h0001) begin
      s_d.pre = 16'h0000;
      s_d.tick = 1'b1;
      s_d.busy = 1'b1;
      s_d.cnt.b0 = c0[7:0];
      if (c0[8]) begin
        s_d.cnt.b1 = c1[7:0];
        if (c1[8]) begin
          s_d.cnt.b2 = c2[7:0];
          if (c2[8]) begin
            s_d.cnt.b3 = c3[7:0];
          end
        end
      end
    end else begin
      s_d.pre = s_q.pre + 16'h0001;
      // Warn one cycle ahead of a change
      s_d.busy = (s_q.pre == PRESCALE - 16'h0002);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;
  assign tick  = s_q.tick;
  assign busy  = s_q.busy;
endmodule // rtcc_counter

// ===== verilog/rtcc_control.sv
// Clock control and status register with AXI4-Lite access and interrupt
`timescale 1ns/1ns
`include "rtcc_defs.svh"
module rtcc_control #(
  parameter logic [15:0] PRESCALE = `RTCC_PRESCALE
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [13:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [13:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);
  typedef struct packed {
    logic [7:0]                ctrl;
    logic [`RTCC_IRQ_W-1:0]    stat;
    logic [`RTCC_IRQ_W-1:0]    mask;
    rtcc_pkg::rtcc_count_t     almv;
    logic                      awHeld;
    logic [13:0]               awAddr;
    logic                      wHeld;
    logic [31:0]               wData;
    logic [3:0]                wStrb;
    rtcc_pkg::rtcc_bus_state_t wrSt;
    logic [1:0]                bresp;
    rtcc_pkg::rtcc_bus_state_t rdSt;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
    logic                      irq;
    logic                      lockSeen;
    logic                      awRdy;
    logic                      wRdy;
    logic                      bValid;
    logic                      arRdy;
    logic                      rValid;
  } rtcc_state_t;

  rtcc_state_t s_q;
  rtcc_state_t s_d;

  rtcc_pkg::rtcc_count_t count;
  logic                  tick;
  logic                  busy;
  logic                  loadCnt;
  rtcc_pkg::rtcc_count_t loadVal;
  logic                  useBcd;
  logic                  alarmHit;

  // Byte-lane merge used by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [13:0] a);
    return a == `RTCC_ADDR_CTRL || a == `RTCC_ADDR_STAT ||
           a == `RTCC_ADDR_MASK || a == `RTCC_ADDR_COUNT ||
           a == `RTCC_ADDR_ALMV;
  endfunction

  assign useBcd = s_q.ctrl[`RTCC_BIT_BCD] & ~s_q.ctrl[`RTCC_BIT_MODE];

  assign alarmHit = (count == s_q.almv);

  rtcc_counter #(
    .PRESCALE (PRESCALE)
  ) u_counter (
    .clock     (clock),
    .rst_b     (rst_b),
    .run       (s_q.ctrl[`RTCC_BIT_LOCK]),
    .useBcd    (useBcd),
    .load      (loadCnt),
    .loadValue (loadVal),
    .count     (count),
    .tick      (tick),
    .busy      (busy)
  );

  always_comb begin
    logic        doWrite;
    logic [31:0] nv;
    logic [7:0]  rdCtrl;
    logic        alarmNow;
    logic        lockRise;
    s_d = s_q;
    rdCtrl = 8'h00;
    alarmNow = 1'b0;
    lockRise = 1'b0;
    loadCnt = 1'b0;
    loadVal = count;
    doWrite = 1'b0;
    nv = 32'h0000_0000;
    // Address and data accepted in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.wHeld = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    if (s_q.wrSt == rtcc_pkg::RTCC_IDLE && s_q.awHeld && s_q.wHeld) begin
      doWrite = 1'b1;
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
      s_d.wrSt = rtcc_pkg::RTCC_RESP;
      s_d.bresp = mapped(s_q.awAddr) ? `RTCC_RESP_OKAY : `RTCC_RESP_SLVERR;
    end
    if (s_q.wrSt == rtcc_pkg::RTCC_RESP && s_axi_bready) begin
      s_d.wrSt = rtcc_pkg::RTCC_IDLE;
    end
    if (doWrite) begin
      unique case (s_q.awAddr)
        `RTCC_ADDR_CTRL: begin
          nv = merge({24'h0, s_q.ctrl}, s_q.wData, s_q.wStrb);
          s_d.ctrl = (s_q.ctrl & ~`RTCC_CTRL_WMASK) |
                     (nv[7:0] & `RTCC_CTRL_WMASK);
        end
        `RTCC_ADDR_MASK: begin
          nv = merge({30'h0, s_q.mask}, s_q.wData, s_q.wStrb);
          s_d.mask = nv[`RTCC_IRQ_W-1:0];
        end
        `RTCC_ADDR_COUNT: begin
          if (!s_q.ctrl[`RTCC_BIT_LOCK]) begin
            loadCnt = 1'b1;
            loadVal = merge(count, s_q.wData, s_q.wStrb);
          end
        end
        `RTCC_ADDR_ALMV: begin
          s_d.almv = merge(s_q.almv, s_q.wData, s_q.wStrb);
        end
        default: begin
        end
      endcase
    end

    // alarm follows lock set and increments
    lockRise = s_q.ctrl[`RTCC_BIT_LOCK] & ~s_q.lockSeen;
    s_d.lockSeen = s_q.ctrl[`RTCC_BIT_LOCK];
    alarmNow = s_q.ctrl[`RTCC_BIT_ALARM];
    if (lockRise || tick) begin
      alarmNow = alarmHit;
    end
    s_d.ctrl[`RTCC_BIT_ALARM] = alarmNow;

    // sync low unless counts may move
    // Gated by lock: once stopped, counts stand still
    s_d.ctrl[`RTCC_BIT_SYNC] = busy & s_q.ctrl[`RTCC_BIT_LOCK];

    // Set wins over a write-one clear
    if (doWrite && s_q.awAddr == `RTCC_ADDR_STAT) begin
      nv = merge({30'h0, s_q.stat}, s_q.wData, s_q.wStrb);
      s_d.stat = s_q.stat & ~nv[`RTCC_IRQ_W-1:0];
    end
    if (alarmNow && !s_q.ctrl[`RTCC_BIT_ALARM]) begin
      s_d.stat[`RTCC_IRQ_ALARM] = 1'b1;
    end
    if (tick) begin
      s_d.stat[`RTCC_IRQ_TICK] = 1'b1;
    end
    s_d.irq = |(s_d.stat & s_d.mask);

    // Read channel, one word in flight
    if (s_q.rdSt == rtcc_pkg::RTCC_IDLE && s_axi_arvalid) begin
      s_d.rdSt = rtcc_pkg::RTCC_RESP;
      s_d.rresp = mapped(s_axi_araddr) ? `RTCC_RESP_OKAY
                                       : `RTCC_RESP_SLVERR;
      rdCtrl = s_q.ctrl;
      unique case (s_axi_araddr)
        `RTCC_ADDR_CTRL:  s_d.rdata = {24'h0, rdCtrl};
        `RTCC_ADDR_STAT:  s_d.rdata = {30'h0, s_q.stat};
        `RTCC_ADDR_MASK:  s_d.rdata = {30'h0, s_q.mask};
        `RTCC_ADDR_COUNT: s_d.rdata = count;
        `RTCC_ADDR_ALMV:  s_d.rdata = s_q.almv;
        default:          s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (s_q.rdSt == rtcc_pkg::RTCC_RESP && s_axi_rready) begin
      s_d.rdSt = rtcc_pkg::RTCC_IDLE;
    end

    // Handshake outputs held in flops, one per port
    s_d.awRdy  = ~s_d.awHeld;
    s_d.wRdy   = ~s_d.wHeld;
    s_d.bValid = (s_d.wrSt == rtcc_pkg::RTCC_RESP);
    s_d.arRdy  = (s_d.rdSt == rtcc_pkg::RTCC_IDLE);
    s_d.rValid = (s_d.rdSt == rtcc_pkg::RTCC_RESP);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      // Ready flags high in reset so the first request is taken
      s_q.awRdy <= 1'b1;
      s_q.wRdy <= 1'b1;
      s_q.arRdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awRdy;
  assign s_axi_wready  = s_q.wRdy;
  assign s_axi_bvalid  = s_q.bValid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arRdy;
  assign s_axi_rvalid  = s_q.rValid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign irq           = s_q.irq;
endmodule // rtcc_control

// ===== dv/rtcc_control_sva.sv
// Bus handshake and control readback checks for the clock control block
`timescale 1ns/1ns
`include "rtcc_defs.svh"
module rtcc_control_sva (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("bvalid dropped before bready");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("bvalid stayed after bready");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  read_delay_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while read pending");
  aw_refuse_a: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("second write address taken");
  write_delay_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer not two cycles after handshake");
  ctrl_spare_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == `RTCC_ADDR_CTRL |=> s_axi_rdata[31:8] == 24'h000000
    && !s_axi_rdata[5] && !s_axi_rdata[2]) else $error("spare bits set");
  sync_idle_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == `RTCC_ADDR_CTRL ##1 !s_axi_rdata[0] |->
    !s_axi_rdata[7]) else $error("sync set while unlocked");
endmodule // rtcc_control_sva

// ===== dv/rtcc_control_tb_top.sv
// Self-checking bench for the clock control register block
`timescale 1ns/1ns
`include "rtcc_defs.svh"
module rtcc_control_tb_top;
  typedef struct {logic [7:0] c; logic [31:0] s; logic [31:0] e;} rtcc_row_t;
  logic clock, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat, keep;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          errCount, comparisons, n;
  // Control, start count, count after first step
  rtcc_row_t rows[6] = '{'{8'h01, 32'h09, 32'h0A}, '{8'h11, 32'h09, 32'h10},
    '{8'h11, 32'h99, 32'h100}, '{8'h19, 32'h09, 32'h0A},
    '{8'h09, 32'hFF, 32'h100}, '{8'h03, 32'h00, 32'h01}};
  // Short step keeps each row near forty cycles
  rtcc_control #(.PRESCALE(16'h0028)) uut (.*);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(logic [13:0] a, logic [31:0] d);
    logic ha, hw, hb;
    @(posedge clock);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'b1;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge clock);
      ha = s_axi_awready & s_axi_awvalid; hw = s_axi_wready & s_axi_wvalid;
      hb = s_axi_bvalid; resp = s_axi_bresp;
      @(posedge clock);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    chk("write answer", 32'h0, 32'h1);
  endtask
  task automatic rd(logic [13:0] a);
    logic ha, hr;
    @(posedge clock);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge clock);
      ha = s_axi_arready & s_axi_arvalid; hr = s_axi_rvalid;
      rdat = s_axi_rdata; resp = s_axi_rresp;
      @(posedge clock);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    chk("read answer", 32'h0, 32'h1);
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    errCount++;
    end_sim();
  end
  initial begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 14'h0000; s_axi_araddr = 14'h0000;
    s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    rd(`RTCC_ADDR_CTRL); chk("ctrl reset", rdat, 32'h0);
    wr(`RTCC_ADDR_CTRL, 32'hC0); rd(`RTCC_ADDR_CTRL);
    chk("ctrl fixed bits", rdat, 32'h0);
    chk("mapped rd", resp, `RTCC_RESP_OKAY);
    wr(14'h0100, 32'h1); chk("unmapped wr", resp, `RTCC_RESP_SLVERR);
    rd(14'h0100); chk("unmapped rd", {rdat[29:0], resp}, 32'h2);
    $display("reset and map test done");
    foreach (rows[i]) begin
      wr(`RTCC_ADDR_CTRL, 32'h0); wr(`RTCC_ADDR_COUNT, rows[i].s);
      wr(`RTCC_ADDR_CTRL, {24'h0, rows[i].c}); rd(`RTCC_ADDR_CTRL);
      chk("ctrl back", rdat & 32'h1B, {24'h0, rows[i].c});
      n = 0;
      do begin
        rd(`RTCC_ADDR_COUNT);
        n++;
      end while (rdat === rows[i].s && n < 100);
      chk("count step", rdat, rows[i].e);
      $display("step row %0d done", i);
    end
    wr(`RTCC_ADDR_CTRL, 32'h0); wr(`RTCC_ADDR_STAT, 32'h3);
    wr(`RTCC_ADDR_MASK, 32'h1); wr(`RTCC_ADDR_COUNT, 32'h20);
    wr(`RTCC_ADDR_ALMV, 32'h20); chk("irq idle", irq, 1'b0);
    chk("mapped wr", resp, `RTCC_RESP_OKAY);
    wr(`RTCC_ADDR_CTRL, 32'h1); rd(`RTCC_ADDR_CTRL);
    chk("alarm on lock", rdat[6], 1'b1);
    rd(`RTCC_ADDR_STAT); chk("alarm event", rdat[0], 1'b1);
    chk("irq raised", irq, 1'b1);
    wr(`RTCC_ADDR_COUNT, 32'h55); rd(`RTCC_ADDR_COUNT);
    chk("locked count", rdat[31:4], 28'h2);
    n = 0;
    do begin
      rd(`RTCC_ADDR_COUNT);
      n++;
    end while (rdat === 32'h20 && n < 100);
    rd(`RTCC_ADDR_CTRL);
    chk("alarm on step", rdat[6], 1'b0);
    wr(`RTCC_ADDR_CTRL, 32'h0); rd(`RTCC_ADDR_COUNT); keep = rdat;
    repeat (100) @(posedge clock);
    rd(`RTCC_ADDR_COUNT); chk("stopped count", rdat, keep);
    rd(`RTCC_ADDR_CTRL); chk("sync idle", rdat[7], 1'b0);
    wr(`RTCC_ADDR_STAT, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq cleared", irq, 1'b0);
    wr(`RTCC_ADDR_COUNT, 32'h55); rd(`RTCC_ADDR_COUNT);
    chk("open count", rdat, 32'h55);
    $display("alarm and lock test done");
    wr(`RTCC_ADDR_CTRL, 32'h1B);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    rd(`RTCC_ADDR_CTRL); chk("ctrl rereset", rdat, 32'h0);
    chk("irq rereset", irq, 1'b0);
    $display("second reset test done");
    end_sim();
  end
endmodule // rtcc_control_tb_top
bind rtcc_control rtcc_control_sva chk_i (.*);
